/* verilog/dsos_pkg.sv */
// Purpose: Shared constants for the drive status output selector.
// Assumes: Frequencies in 0.1 Hz units, currents in percent of rated.
// Notes: Register offsets are byte addresses on a 32-bit Wishbone bus.
package dsos_pkg;
    // Register byte offsets
    localparam logic [4:0] DSOS_OFS_SELECT = 5'h00;
    localparam logic [4:0] DSOS_OFS_MASK = 5'h04;
    localparam logic [4:0] DSOS_OFS_LEVEL = 5'h08;
    localparam logic [4:0] DSOS_OFS_BAND = 5'h0C;
    localparam logic [4:0] DSOS_OFS_MAXF = 5'h10;
    localparam logic [4:0] DSOS_OFS_THERM = 5'h14;
    localparam logic [4:0] DSOS_OFS_STATUS = 5'h18;
    // Field positions
    localparam int DSOS_SEL_OC_LSB = 0;
    localparam int DSOS_SEL_RLY_LSB = 8;
    localparam int DSOS_TH_EN_BIT = 0;
    localparam int DSOS_TH_COOL_BIT = 1;
    localparam int DSOS_TH_ONE_LSB = 8;
    localparam int DSOS_TH_CONT_LSB = 16;
    localparam int DSOS_ST_OC_BIT = 0;
    localparam int DSOS_ST_RLY_BIT = 1;
    localparam int DSOS_ST_HYST_BIT = 2;
    localparam int DSOS_ST_TRIP_BIT = 8;
    localparam int DSOS_ST_REJ_BIT = 9;
    localparam int DSOS_ST_HEAT_LSB = 16;
    // Reset values
    localparam logic [4:0] DSOS_RST_OC_SEL = 5'h0C;
    localparam logic [4:0] DSOS_RST_RLY_SEL = 5'h11;
    localparam logic [2:0] DSOS_RST_MASK = 3'h2;
    localparam logic [15:0] DSOS_RST_LEVEL = 16'h012C;
    localparam logic [15:0] DSOS_RST_BAND = 16'h0064;
    localparam logic [15:0] DSOS_RST_MAXF = 16'h0FA0;
    localparam logic [7:0] DSOS_RST_ONE_MIN = 8'h96;
    localparam logic [7:0] DSOS_RST_CONT = 8'h64;
    // Limits
    localparam logic [15:0] DSOS_FREQ_LIMIT = 16'h0FA0;
    localparam logic [4:0] DSOS_CODE_MAX = 5'h11;
    localparam logic [7:0] DSOS_TH_MIN = 8'h32;
    localparam logic [7:0] DSOS_TH_MAX = 8'h96;
    localparam logic [15:0] DSOS_LOW_SPEED = 16'h00C8;
    // Selection codes
    localparam logic [4:0] DSOS_CODE_FAULT = 5'h11;
    // Thermal timing
    localparam int DSOS_CLK_NS = 10;
    localparam int DSOS_TICK_NS = 10000000;
    localparam int DSOS_TICK_CYCLES = DSOS_TICK_NS / DSOS_CLK_NS;
    localparam int DSOS_MINUTE_MS = 60000;
    localparam int DSOS_TICKS_PER_MIN = DSOS_MINUTE_MS / (DSOS_TICK_NS / 1000000);
endpackage

/* verilog/dsos_top.sv */
// Purpose: Selects drive conditions for the open-collector and relay outputs.
// Assumes: All status inputs synchronous to clk_i; Wishbone classic slave.
// Notes: Also holds the inverse-time motor thermal model.
//
// Contract
// - Each output picks one condition by code
// - Code 0: command near output frequency
// - Band 0..400 Hz, default 10, max-limited
// - Code 1: command equals level and code 0
// - Level 0..400 Hz, default 30, max-limited
// - Code 2: running frequency within level window
// - Code 3: level reached with decel hysteresis
// - Code 4: inverse of code 3
// - Codes 5-7 route overload and stall flags
// - Code 8: overvoltage trip
// - Code 9: undervoltage trip
// - Code 10: heatsink overheat
// - Code 11: frequency command lost
// - Code 12: running and producing voltage
// - Code 13 stopped, code 14 steady speed
// - Code 15 speed search, 16 awaiting run
// - Code 17 follows the fault mask
// - Mask 2: any trip except undervoltage
// - Enabled thermal model trips on overload
// - One-minute level 50..150, default 150
// - Continuous level default 100, not above
// - Cooling type 0 shaft fan, 1 separate
//
// Chosen here: the register addresses and the Wishbone slave port.
`timescale 1ns/1ns
module dsos_top
    import dsos_pkg::*;
#(
    parameter int TICK_CYCLES = DSOS_TICK_CYCLES,
    parameter int FREQ_W = 16
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [4:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire logic [FREQ_W-1:0] cmd_freq_i,
    input wire logic [FREQ_W-1:0] run_freq_i,
    input wire logic motor_overload_warning_i,
    input wire logic drive_overload_flag_i,
    input wire logic stall_active_i,
    input wire logic overvoltage_trip_i,
    input wire logic undervoltage_trip_i,
    input wire logic heatsink_overtemp_flag_i,
    input wire logic command_loss_i,
    input wire logic run_command_i,
    input wire logic output_voltage_i,
    input wire logic stopped_i,
    input wire logic steady_speed_i,
    input wire logic speed_search_i,
    input wire logic wait_run_i,
    input wire logic other_trip_i,
    input wire logic restart_attempt_i,
    input wire logic [7:0] motor_current_i,
    output logic open_collector_output_o,
    output logic relay_contact_output_o,
    output logic thermal_trip_o
);
    localparam int HEAT_W = 24;

    logic [4:0] transistor_output_select_r;
    logic [4:0] relay_output_select_r;
    logic [2:0] fault_output_mask_r;
    logic [FREQ_W-1:0] detect_level_r;
    logic [FREQ_W-1:0] detect_band_r;
    logic [FREQ_W-1:0] max_frequency_limit_r;
    logic thermal_protect_enable_r;
    logic motor_cooling_type_r;
    logic [7:0] thermal_one_minute_level_r;
    logic [7:0] thermal_continuous_level_r;
    logic reject_r;
    logic level_hysteresis_r;
    logic thermal_trip_r;
    logic [HEAT_W-1:0] heat_r;
    logic [31:0] tick_cnt_r;
    logic wr_stb;
    logic [31:0] wr_word;
    logic [31:0] rd_word;
    logic [31:0] cur_word;
    logic [17:0] cond;
    logic speed_reached_flag;
    logic level_reached_flag;
    logic level_window_flag;
    logic level_hysteresis_inverted_flag;
    logic fault_out;
    logic [FREQ_W-1:0] half_band;
    logic [FREQ_W:0] hyst_low;
    logic sel_ok;
    logic mask_ok;
    logic freq_ok;
    logic maxf_ok;
    logic therm_ok;
    logic wr_ok;
    logic [7:0] cont_eff;
    logic [HEAT_W-1:0] heat_limit;
    logic [HEAT_W-1:0] excess;
    logic [HEAT_W:0] heat_sum;
    logic tick;

    function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                          input logic [3:0] lanes);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (lanes[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic [FREQ_W-1:0] abs_diff(input logic [FREQ_W-1:0] a,
                                                   input logic [FREQ_W-1:0] b);
        return (a >= b) ? (a - b) : (b - a);
    endfunction

    // Frequency setting is legal up to 400 Hz and the configured maximum
    function automatic logic freq_valid(input logic [FREQ_W-1:0] f,
                                        input logic [FREQ_W-1:0] fmax);
        return (f <= FREQ_W'(DSOS_FREQ_LIMIT)) && (f <= fmax);
    endfunction

    function automatic logic pick(input logic [17:0] c, input logic [4:0] code);
        return (code <= DSOS_CODE_MAX) ? c[code] : 1'b0;
    endfunction

    // Shared window test for codes 0 and 2
    function automatic logic near(input logic [FREQ_W-1:0] a, input logic [FREQ_W-1:0] b,
                                  input logic [FREQ_W-1:0] half);
        return abs_diff(a, b) <= half;
    endfunction

    // Write-one-to-clear decode of the status word
    function automatic logic w1c(input logic hit, input logic [4:0] a, input logic [31:0] w,
                                 input int pos);
        return hit && (a == DSOS_OFS_STATUS) && w[pos];
    endfunction

    // Bus decode
    assign wr_stb = cyc_i && stb_i && we_i && ack_o;
    always_comb begin
        unique case (adr_i)
            DSOS_OFS_SELECT: begin
                cur_word = '0;
                cur_word[DSOS_SEL_OC_LSB +: 5] = transistor_output_select_r;
                cur_word[DSOS_SEL_RLY_LSB +: 5] = relay_output_select_r;
            end
            DSOS_OFS_MASK: cur_word = {29'h0, fault_output_mask_r};
            DSOS_OFS_LEVEL: cur_word = 32'(detect_level_r);
            DSOS_OFS_BAND: cur_word = 32'(detect_band_r);
            DSOS_OFS_MAXF: cur_word = 32'(max_frequency_limit_r);
            DSOS_OFS_THERM: begin
                cur_word = '0;
                cur_word[DSOS_TH_EN_BIT] = thermal_protect_enable_r;
                cur_word[DSOS_TH_COOL_BIT] = motor_cooling_type_r;
                cur_word[DSOS_TH_ONE_LSB +: 8] = thermal_one_minute_level_r;
                cur_word[DSOS_TH_CONT_LSB +: 8] = thermal_continuous_level_r;
            end
            DSOS_OFS_STATUS: begin
                cur_word = '0;
                cur_word[DSOS_ST_OC_BIT] = open_collector_output_o;
                cur_word[DSOS_ST_RLY_BIT] = relay_contact_output_o;
                cur_word[DSOS_ST_HYST_BIT] = level_hysteresis_r;
                cur_word[DSOS_ST_TRIP_BIT] = thermal_trip_r;
                cur_word[DSOS_ST_REJ_BIT] = reject_r;
                cur_word[DSOS_ST_HEAT_LSB +: 16] = heat_r[HEAT_W-1 -: 16];
            end
            default: cur_word = '0;
        endcase
    end
    assign rd_word = cur_word;
    assign wr_word = merge(cur_word, dat_i, sel_i);

    // Write checks; a failing write leaves the register untouched
    assign sel_ok = (wr_word[DSOS_SEL_OC_LSB +: 8] <= 8'(DSOS_CODE_MAX))
        && (wr_word[DSOS_SEL_RLY_LSB +: 8] <= 8'(DSOS_CODE_MAX));
    assign mask_ok = (wr_word[31:3] == '0);
    assign freq_ok = (wr_word[31:FREQ_W] == '0)
        && freq_valid(wr_word[FREQ_W-1:0], max_frequency_limit_r);
    assign maxf_ok = (wr_word[31:FREQ_W] == '0)
        && (wr_word[FREQ_W-1:0] <= FREQ_W'(DSOS_FREQ_LIMIT));
    assign therm_ok = (wr_word[DSOS_TH_ONE_LSB +: 8] >= DSOS_TH_MIN)
        && (wr_word[DSOS_TH_ONE_LSB +: 8] <= DSOS_TH_MAX)
        && (wr_word[DSOS_TH_CONT_LSB +: 8] >= DSOS_TH_MIN)
        && (wr_word[DSOS_TH_CONT_LSB +: 8] <= wr_word[DSOS_TH_ONE_LSB +: 8]);
    always_comb begin
        unique case (adr_i)
            DSOS_OFS_SELECT: wr_ok = sel_ok;
            DSOS_OFS_MASK: wr_ok = mask_ok;
            DSOS_OFS_LEVEL: wr_ok = freq_ok;
            DSOS_OFS_BAND: wr_ok = freq_ok;
            DSOS_OFS_MAXF: wr_ok = maxf_ok;
            DSOS_OFS_THERM: wr_ok = therm_ok;
            default: wr_ok = 1'b1;
        endcase
    end

    // One wait state; ack drops the cycle after it is given
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
        end else begin
            ack_o <= cyc_i && stb_i && !ack_o;
        end
    end

    // Read data only in the ack cycle, so an idle bus reads as zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_o <= '0;
        end else begin
            dat_o <= (cyc_i && stb_i && !ack_o && !we_i) ? rd_word : '0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            transistor_output_select_r <= DSOS_RST_OC_SEL;
            relay_output_select_r <= DSOS_RST_RLY_SEL;
            fault_output_mask_r <= DSOS_RST_MASK;
            detect_level_r <= FREQ_W'(DSOS_RST_LEVEL);
            detect_band_r <= FREQ_W'(DSOS_RST_BAND);
            max_frequency_limit_r <= FREQ_W'(DSOS_RST_MAXF);
            thermal_protect_enable_r <= 1'b0;
            motor_cooling_type_r <= 1'b0;
            thermal_one_minute_level_r <= DSOS_RST_ONE_MIN;
            thermal_continuous_level_r <= DSOS_RST_CONT;
        end else if (wr_stb && wr_ok) begin
            unique case (adr_i)
                DSOS_OFS_SELECT: begin
                    transistor_output_select_r <= wr_word[DSOS_SEL_OC_LSB +: 5];
                    relay_output_select_r <= wr_word[DSOS_SEL_RLY_LSB +: 5];
                end
                DSOS_OFS_MASK: fault_output_mask_r <= wr_word[2:0];
                DSOS_OFS_LEVEL: detect_level_r <= wr_word[FREQ_W-1:0];
                DSOS_OFS_BAND: detect_band_r <= wr_word[FREQ_W-1:0];
                DSOS_OFS_MAXF: max_frequency_limit_r <= wr_word[FREQ_W-1:0];
                DSOS_OFS_THERM: begin
                    thermal_protect_enable_r <= wr_word[DSOS_TH_EN_BIT];
                    motor_cooling_type_r <= wr_word[DSOS_TH_COOL_BIT];
                    thermal_one_minute_level_r <= wr_word[DSOS_TH_ONE_LSB +: 8];
                    thermal_continuous_level_r <= wr_word[DSOS_TH_CONT_LSB +: 8];
                end
                default: ;
            endcase
        end
    end

    // Sticky refusal flag, write one to clear; a new refusal wins
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            reject_r <= 1'b0;
        end else if (wr_stb && !wr_ok) begin
            reject_r <= 1'b1;
        end else if (w1c(wr_stb, adr_i, wr_word, DSOS_ST_REJ_BIT)) begin
            reject_r <= 1'b0;
        end
    end

    // Frequency detectors
    assign half_band = detect_band_r >> 1;
    assign speed_reached_flag = near(cmd_freq_i, run_freq_i, half_band);
    assign level_reached_flag = (cmd_freq_i == detect_level_r) && speed_reached_flag;
    assign level_window_flag = near(detect_level_r, run_freq_i, half_band);
    assign hyst_low = {1'b0, detect_level_r} - {1'b0, half_band};

    // Set at level, held while above level minus half band
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            level_hysteresis_r <= 1'b0;
        end else if (run_freq_i >= detect_level_r) begin
            level_hysteresis_r <= 1'b1;
        // Half band (band >> 1) above the level leaves no lower threshold, so it holds
        end else if (!hyst_low[FREQ_W] && {1'b0, run_freq_i} <= hyst_low) begin
            level_hysteresis_r <= 1'b0;
        end
    end
    assign level_hysteresis_inverted_flag = !level_hysteresis_r;

    // Thermal trip counts as a trip other than undervoltage
    assign fault_out = (fault_output_mask_r[0] && undervoltage_trip_i)
        || (fault_output_mask_r[1] && (other_trip_i || overvoltage_trip_i
            || heatsink_overtemp_flag_i || thermal_trip_r))
        || (fault_output_mask_r[2] && restart_attempt_i);

    always_comb begin
        cond[0] = speed_reached_flag;
        cond[1] = level_reached_flag;
        cond[2] = level_window_flag;
        cond[3] = level_hysteresis_r;
        cond[4] = level_hysteresis_inverted_flag;
        cond[5] = motor_overload_warning_i;
        cond[6] = drive_overload_flag_i;
        cond[7] = stall_active_i;
        cond[8] = overvoltage_trip_i;
        cond[9] = undervoltage_trip_i;
        cond[10] = heatsink_overtemp_flag_i;
        cond[11] = command_loss_i;
        cond[12] = run_command_i && output_voltage_i;
        cond[13] = stopped_i;
        cond[14] = steady_speed_i;
        cond[15] = speed_search_i;
        cond[16] = wait_run_i;
        cond[17] = fault_out;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            open_collector_output_o <= 1'b0;
            relay_contact_output_o <= 1'b0;
        end else begin
            open_collector_output_o <= pick(cond, transistor_output_select_r);
            relay_contact_output_o <= pick(cond, relay_output_select_r);
        end
    end

    // Thermal tick prescaler
    assign tick = (tick_cnt_r == 32'(TICK_CYCLES - 1));
    always_ff @(posedge clk_i) begin
        if (rst_i || tick) begin
            tick_cnt_r <= '0;
        end else begin
            tick_cnt_r <= tick_cnt_r + 32'h1;
        end
    end

    // Shaft fan cools less at low speed, so derate the continuous level
    assign cont_eff = (!motor_cooling_type_r && run_freq_i < FREQ_W'(DSOS_LOW_SPEED))
        ? (thermal_continuous_level_r - (thermal_continuous_level_r >> 2))
        : thermal_continuous_level_r;
    // Heat grows with excess current; one-minute level trips after one minute
    assign heat_limit = HEAT_W'((thermal_one_minute_level_r - cont_eff) * DSOS_TICKS_PER_MIN);
    assign excess = (motor_current_i > cont_eff) ? HEAT_W'(motor_current_i - cont_eff) : '0;
    assign heat_sum = {1'b0, heat_r} + {1'b0, excess};

    always_ff @(posedge clk_i) begin
        if (rst_i || !thermal_protect_enable_r) begin
            heat_r <= '0;
        end else if (tick) begin
            if (excess != '0) begin
                // Saturate rather than wrap back to cool during a long overload
                heat_r <= heat_sum[HEAT_W] ? '1 : heat_sum[HEAT_W-1:0];
            end else if (heat_r != '0) begin
                heat_r <= heat_r - HEAT_W'(1);
            end
        end
    end

    // Trip is sticky until cleared; a fresh overload wins over the clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            thermal_trip_r <= 1'b0;
        end else if (thermal_protect_enable_r && heat_r >= heat_limit && heat_r != '0) begin
            thermal_trip_r <= 1'b1;
        end else if (w1c(wr_stb, adr_i, wr_word, DSOS_ST_TRIP_BIT)) begin
            thermal_trip_r <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            thermal_trip_o <= 1'b0;
        end else begin
            thermal_trip_o <= thermal_trip_r;
        end
    end
endmodule

/* bench/dsos_drive_model.sv */
// Purpose: Outside sequence feeding drive conditions to the selector.
// Assumes: Bench sets one condition vector, bit n for code n.
// Notes: One-edge lag, as a real sequence would show.
`timescale 1ns/1ns
module dsos_drive_model (
    input wire logic clk_i,
    input wire logic [19:0] cond_i,
    output logic [19:0] line_o
);
    initial line_o = 20'h0;
    always @(posedge clk_i) begin
        line_o <= cond_i;
    end
endmodule

/* bench/dsos_monitor.sv */
// Purpose: Port checks for the status output selector.
// Assumes: Select and mask written as full words.
// Notes: Shadows track legal mask writes and select writes whose 5-bit codes are up to 17.
`timescale 1ns/1ns
module dsos_monitor
    import dsos_pkg::*;
#(parameter int TICK_CYCLES = DSOS_TICK_CYCLES, parameter int FREQ_W = 16) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [4:0] adr_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    input wire logic undervoltage_trip_i,
    input wire logic run_command_i,
    input wire logic output_voltage_i,
    input wire logic stopped_i,
    input wire logic other_trip_i,
    input wire logic open_collector_output_o,
    input wire logic relay_contact_output_o,
    input wire logic thermal_trip_o
);
    logic [4:0] oc_r, rly_r;
    logic [2:0] msk_r;
    logic wr;
    assign wr = cyc_i && stb_i && we_i && ack_o;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            oc_r <= DSOS_RST_OC_SEL;
            rly_r <= DSOS_RST_RLY_SEL;
            msk_r <= DSOS_RST_MASK;
        end else if (wr && adr_i == DSOS_OFS_MASK && dat_i[31:3] == 29'h0) begin
            msk_r <= dat_i[2:0];
        end else if (wr && adr_i == DSOS_OFS_SELECT && dat_i[4:0] <= DSOS_CODE_MAX
            && dat_i[12:8] <= DSOS_CODE_MAX) begin
            oc_r <= dat_i[4:0];
            rly_r <= dat_i[12:8];
        end
    end
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    sequence req_s;
        cyc_i && stb_i && !ack_o;
    endsequence
    sequence one_ack_s;
        ack_o ##1 !ack_o;
    endsequence
    ack_answer_a: assert property (req_s |=> one_ack_s)
        else $error("Access not answered by one ack");
    dat_idle_a: assert property (!ack_o |-> dat_o == 32'h0)
        else $error("Read data outside ack");
    reset_quiet_a: assert property (disable iff (1'b0)
        rst_i |=> !open_collector_output_o && !relay_contact_output_o && !thermal_trip_o)
        else $error("Output active after reset");
    stop_follow_a: assert property (oc_r == 5'h0D |=>
        open_collector_output_o == $past(stopped_i)) else $error("Stop not followed");
    run_follow_a: assert property (oc_r == 5'h0C |=>
        open_collector_output_o == $past(run_command_i && output_voltage_i))
        else $error("Run not followed");
    uv_relay_a: assert property (rly_r == DSOS_CODE_FAULT && msk_r == 3'h1 |=>
        relay_contact_output_o == $past(undervoltage_trip_i)) else $error("Mask 1 wrong");
    trip_relay_a: assert property (rly_r == DSOS_CODE_FAULT && msk_r[1] && other_trip_i
        |=> relay_contact_output_o) else $error("Trip not on relay");
    sel_write_a: assert property (wr && adr_i == DSOS_OFS_SELECT && dat_i[4:0] == 5'h0D
        && dat_i[12:8] <= 5'h11 ##1 stopped_i |=> open_collector_output_o)
        else $error("New code not applied");
endmodule
bind dsos_top dsos_monitor #(.TICK_CYCLES(TICK_CYCLES), .FREQ_W(FREQ_W)) u_mon (.*);

/* bench/dsos_drive_status_output_select_tb.sv */
// Purpose: Self-checking bench for the status output selector.
// Assumes: Thermal tick cut to 4 clocks.
// Notes: Conditions pass through the drive model.
`timescale 1ns/1ns
module dsos_drive_status_output_select_tb;
    import dsos_pkg::*;
    logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
    logic [4:0] adr_i = 5'h00;
    logic [3:0] sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0, dat_o, rd;
    logic ack_o, open_collector_output_o, relay_contact_output_o, thermal_trip_o;
    logic [15:0] cmd_freq_i = 16'h0, run_freq_i = 16'h0;
    logic [7:0] motor_current_i = 8'h00;
    logic [19:0] cond = 20'h0, line;
    int mismatches = 0, num_checks = 0;
    wire logic motor_overload_warning_i, drive_overload_flag_i, stall_active_i, wait_run_i;
    wire logic overvoltage_trip_i, undervoltage_trip_i, heatsink_overtemp_flag_i, stopped_i;
    wire logic command_loss_i, run_command_i, output_voltage_i, steady_speed_i;
    wire logic speed_search_i, other_trip_i, restart_attempt_i;
    logic [31:0] rv [8] = '{32'h110C, 32'h2, 32'h12C, 32'h64, 32'hFA0, 32'h649600, 0, 0};
    logic [4:0] ba [8] = '{5'h00, 5'h00, 5'h04, 5'h0C, 5'h08, 5'h10, 5'h14, 5'h14};
    logic [31:0] bd [8] = '{32'h12, 32'h1200, 32'h8, 32'hFA1, 32'hFA1, 32'hFA1,
        32'h649700, 32'h979600};
    int ft [9][4] = '{'{0, 300, 250, 1}, '{0, 300, 249, 0}, '{0, 250, 300, 1},
        '{1, 300, 260, 1}, '{1, 310, 310, 0}, '{2, 0, 350, 1}, '{2, 0, 351, 0},
        '{2, 0, 250, 1}, '{2, 0, 249, 0}};
    int hs [6][2] = '{'{0, 0}, '{299, 0}, '{300, 1}, '{251, 1}, '{250, 0}, '{299, 0}};
    int mt [8][3] = '{'{1, 'h200, 1}, '{1, 'h20000, 0}, '{2, 'h20000, 1}, '{2, 'h200, 0},
        '{4, 'h40000, 1}, '{4, 'h20000, 0}, '{3, 'h200, 1}, '{0, 'h20000, 0}};
    always #5 clk_i = ~clk_i;
    assign {output_voltage_i, restart_attempt_i, other_trip_i, wait_run_i, speed_search_i,
        steady_speed_i, stopped_i, run_command_i, command_loss_i, heatsink_overtemp_flag_i,
        undervoltage_trip_i, overvoltage_trip_i, stall_active_i, drive_overload_flag_i,
        motor_overload_warning_i} = line[19:5];
    dsos_drive_model drv (.clk_i(clk_i), .cond_i(cond), .line_o(line));
    dsos_top #(.TICK_CYCLES(4)) uut (.*);
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // Ack is sampled before the edge updates land
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        int n;
        n = 0;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        sel_i <= 4'hF;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 16);
        if (ack_o !== 1'b1) begin
            mismatches++;
            end_sim();
        end
        rd = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        @(posedge clk_i);
    endtask
    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        for (int i = 0; i < 8; i++) begin
            bus(1'b0, 5'(4 * i), 32'h0);
            check(rd, rv[i]);
        end
        // Refused values keep the old one and raise the refusal flag
        for (int i = 0; i < 8; i++) begin
            bus(1'b1, ba[i], bd[i]);
            bus(1'b0, ba[i], 32'h0);
            check(rd, rv[ba[i][4:2]]);
            bus(1'b0, DSOS_OFS_STATUS, 32'h0);
            check(rd, 32'h200);
            bus(1'b1, DSOS_OFS_STATUS, 32'h200);
        end
        for (int c = 5; c <= 16; c++) begin
            bus(1'b1, DSOS_OFS_SELECT, 32'h1100 | c);
            cond <= 20'h80000 | (20'h1 << c);
            repeat (3) @(posedge clk_i);
            check(open_collector_output_o, 32'h1);
            check(relay_contact_output_o, 32'(c == 8 || c == 10));
            cond <= 20'h80000;
            repeat (3) @(posedge clk_i);
            check(open_collector_output_o, 32'h0);
        end
        bus(1'b1, DSOS_OFS_SELECT, 32'h110C);
        cond <= 20'h01000;
        repeat (3) @(posedge clk_i);
        check(open_collector_output_o, 32'h0);
        cond <= 20'h0;
        for (int i = 0; i < 9; i++) begin
            bus(1'b1, DSOS_OFS_SELECT, 32'h1100 | ft[i][0]);
            cmd_freq_i <= 16'(ft[i][1]);
            run_freq_i <= 16'(ft[i][2]);
            repeat (3) @(posedge clk_i);
            check(open_collector_output_o, 32'(ft[i][3]));
        end
        bus(1'b1, DSOS_OFS_SELECT, 32'h0403);
        for (int i = 0; i < 6; i++) begin
            run_freq_i <= 16'(hs[i][0]);
            repeat (4) @(posedge clk_i);
            check(open_collector_output_o, 32'(hs[i][1]));
            check(relay_contact_output_o, 32'(!hs[i][1]));
        end
        // Half band above the level: nothing to fall to, flag holds
        bus(1'b1, DSOS_OFS_BAND, 32'h2BC);
        run_freq_i <= 16'h12C;
        repeat (4) @(posedge clk_i);
        run_freq_i <= 16'h0;
        repeat (4) @(posedge clk_i);
        check(open_collector_output_o, 32'h1);
        bus(1'b1, DSOS_OFS_BAND, 32'h64);
        bus(1'b1, DSOS_OFS_SELECT, 32'h1100);
        for (int i = 0; i < 8; i++) begin
            bus(1'b1, DSOS_OFS_MASK, 32'(mt[i][0]));
            cond <= 20'(mt[i][1]);
            repeat (3) @(posedge clk_i);
            check(relay_contact_output_o, 32'(mt[i][2]));
            cond <= 20'h0;
        end
        // Short tick: one-minute 60, continuous 50, separate fan; stop shown meanwhile
        @(posedge clk_i);
        cond <= 20'h02000;
        bus(1'b1, DSOS_OFS_SELECT, 32'h0D0D);
        motor_current_i <= 8'hFF;
        bus(1'b1, DSOS_OFS_THERM, 32'h00323C03);
        repeat (1100) @(posedge clk_i);
        check(open_collector_output_o, 32'h1);
        check(thermal_trip_o, 32'h0);
        for (int n = 0; n < 200 && thermal_trip_o !== 1'b1; n++) @(posedge clk_i);
        check(thermal_trip_o, 32'h1);
        bus(1'b0, DSOS_OFS_STATUS, 32'h0);
        check(rd & 32'h100, 32'h100);
        end_sim();
    end
endmodule
